// file: pkg/clf_pkg.sv
// Purpose: shared constants and types for the current-limit lock fault block
// Assumes: 20 MHz core clock, plain register port with 8-bit byte address
// Notes:   every offset, configuration, status and control field position, configuration and mask reset value and timing count lives here
`default_nettype none

package clf_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ        = 20_000_000;
  localparam int HZ_PER_MHZ         = 1_000_000;
  localparam int CYCLES_PER_US      = CLK_FREQ_HZ / HZ_PER_MHZ;
  localparam int LOCK_RETRY_TIME_MS = 500;
  localparam int LOCK_RETRY_CYCLES  = (CLK_FREQ_HZ / 1000) * LOCK_RETRY_TIME_MS;
  localparam int DEG_CNT_W          = 8;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFS_CFG2     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_MASK     = 8'h08;
  localparam logic [7:0]  OFS_CTRL     = 8'h0C;
  localparam logic [7:0]  OFS_STATE    = 8'h10;
  localparam logic [31:0] CFG2_RESET   = 32'h0000_0000;
  localparam logic [2:0]  MASK_RESET   = 3'h0;

  // fault_configuration_two fields
  localparam int THR_LSB     = 19;
  localparam int REACT_LSB   = 15;
  localparam int DEG_LSB     = 12;
  localparam int RSVD_BIT    = 11;
  localparam int RETRY_LSB   = 0;

  // status / mask bits
  localparam int STATUS_W    = 3;
  localparam int ST_DETECT   = 0;
  localparam int ST_LATCH    = 1;
  localparam int ST_AUTOCLR  = 2;

  // control bits
  localparam int CTRL_CLEAR   = 0;
  localparam int CTRL_RESTART = 1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    CLF_IDLE    = 2'b00,
    CLF_WAIT    = 2'b01,
    CLF_LATCHED = 2'b10
  } clf_state_t;

  typedef enum logic [1:0] {
    CLF_ACT_TRISTATE = 2'b00,
    CLF_ACT_RECIRC   = 2'b01,
    CLF_ACT_HS_BRAKE = 2'b10,
    CLF_ACT_LS_BRAKE = 2'b11
  } clf_action_t;

  // retry limit code to attempts, zero means no limit
  function automatic logic [4:0] clf_retry_limit(input logic [2:0] code);
    case (code)
      3'h1:    clf_retry_limit = 5'h02;
      3'h2:    clf_retry_limit = 5'h03;
      3'h3:    clf_retry_limit = 5'h05;
      3'h4:    clf_retry_limit = 5'h07;
      3'h5:    clf_retry_limit = 5'h0A;
      3'h6:    clf_retry_limit = 5'h0F;
      3'h7:    clf_retry_limit = 5'h14;
      default: clf_retry_limit = 5'h00;
    endcase
  endfunction

endpackage

`default_nettype wire

// file: hdl/clf_deglitch.sv
// Purpose: deglitch filter for the current-limit lock condition
// Assumes: cond_in is already synchronous to core_clk
// Notes:   code 0 passes the level with one register of delay
`default_nettype none

module clf_deglitch
  import clf_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // filter
  input  wire logic       cond_in,
  input  wire logic [2:0] deg_code,
  output var  logic       cond_out
);

  logic [DEG_CNT_W-1:0] cnt_reg;
  logic [DEG_CNT_W-1:0] target;

  // persistence needed in cycles: code microseconds
  assign target = DEG_CNT_W'(deg_code) * DEG_CNT_W'(CYCLES_PER_US);

  // condition must persist target samples before it is passed on
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !cond_in)
    begin
      cnt_reg  <= '0;
      cond_out <= 1'b0;
    end
    else if (deg_code == 3'h0)
      cond_out <= 1'b1; // R7
    else if (cnt_reg == target - 1'b1)
      cond_out <= 1'b1; // R7
    else if (!cond_out)
      cnt_reg <= cnt_reg + 1'b1;
  end

  a_deg_persist: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
    $rose(cond_out) && $past(deg_code) != 3'h0 |-> $past(cond_in) && $past(cnt_reg) == $past(target) - 1'b1)
    else $error("deglitch output rose before the persistence time");

endmodule

`default_nettype wire

// file: hdl/clf_retry_timer.sv
// Purpose: lock retry interval timer
// Assumes: run stays high for the whole wait
// Notes:   done is one cycle long; dropping run restarts the interval
`default_nettype none

module clf_retry_timer
  import clf_pkg::*;
#(
  parameter int CYCLES = LOCK_RETRY_CYCLES
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // timer
  input  wire logic run,
  output var  logic done
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_reg;

  // count while the fault waits, pulse once at the end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !run || done)
    begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end
    else if (cnt_reg == W'(CYCLES - 1))
      done <= 1'b1;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

endmodule

`default_nettype wire

// file: hdl/clf_lock_fault_ctrl.sv
// Purpose: current-limit lock detection, fault reaction and retry control
// Assumes: gate commands come from logic on core_clk, limit_hit is a raw pin
// Notes:   registers reached over a plain port, read data one cycle later
//
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none

// What this block does
// (R1) holds a 3-bit no-motor threshold code, 0.03125 A up to 0.625 A
// (R2) reaction codes 0-3 latch the fault, assert fault pin, pick stage state
// (R3) codes 4-7 clear the fault after the retry interval, same stage states
// (R4) automatic retries are counted; beyond the limit the fault latches
// (R5) high-side brake turns all high FETs on, low-side brake all low FETs
// (R6) codes 8-15 disable detection, no fault raised from this source
// (R7) deglitch code 0 means none, 1-7 means that many microseconds
// (R8) bit 11 of the configuration register is reserved, no function
// (R9) clearing or restarting resets the retry counter to zero
module clf_lock_fault_ctrl
  import clf_pkg::*;
#(
  parameter int RETRY_CYCLES = LOCK_RETRY_CYCLES
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  // current limit comparator
  input  wire logic              limit_hit,
  output var  logic [2:0]        no_motor_current_threshold,
  // gate commands from the motor controller
  input  wire logic [2:0]        hs_cmd,
  input  wire logic [2:0]        ls_cmd,
  // power stage
  output var  logic [2:0]        hs_gate,
  output var  logic [2:0]        ls_gate,
  output var  logic              stage_hiz,
  output var  logic              stage_recirc,
  // fault and interrupt
  output var  logic              fault_indication_out_n,
  output var  logic              irq
);

  // ****************************************************************
  // registers and decoded fields
  // ****************************************************************
  logic [DATA_W-1:0]   cfg2_reg;
  logic [STATUS_W-1:0] status_reg;
  logic [STATUS_W-1:0] status_next;
  logic [STATUS_W-1:0] mask_reg;
  logic [STATUS_W-1:0] status_set;
  logic [STATUS_W-1:0] w1c;
  clf_state_t          state_reg;
  clf_state_t          state_next;
  logic [4:0]          retry_cnt_reg;
  logic [4:0]          retry_cnt_next;
  logic [2:0]          sync_reg;
  logic                limit_level_reg;
  logic                limit_filt;
  logic                retry_done;

  logic [3:0]  current_limit_lock_reaction;
  logic [2:0]  current_limit_lock_deglitch;
  logic [2:0]  retry_code;
  logic [4:0]  retry_count_limit;
  logic        det_off;
  logic        det_auto;
  clf_action_t det_action;
  logic        det_evt;
  logic        wr_cfg2;
  logic        wr_ctrl;
  logic        fault_clear;
  logic        fault_restart;
  logic        cnt_over;

  // field decode; bit 11 is stored but steers nothing
  assign current_limit_lock_reaction = cfg2_reg[REACT_LSB +: 4];
  assign current_limit_lock_deglitch = cfg2_reg[DEG_LSB +: 3];
  assign retry_code                  = cfg2_reg[RETRY_LSB +: 3];
  assign retry_count_limit           = clf_retry_limit(retry_code);

  // reaction code split: top bit disables, next selects auto retry
  assign det_off    = current_limit_lock_reaction[3]; // R6
  assign det_auto   = current_limit_lock_reaction[2]; // R3
  assign det_action = clf_action_t'(current_limit_lock_reaction[1:0]); // R2

  // write decode
  assign wr_cfg2       = reg_wr && (reg_addr == OFS_CFG2);
  assign wr_ctrl       = reg_wr && (reg_addr == OFS_CTRL);
  assign fault_clear   = wr_ctrl && reg_wdata[CTRL_CLEAR];
  assign fault_restart = wr_ctrl && reg_wdata[CTRL_RESTART];
  assign w1c           = (reg_wr && reg_addr == OFS_STATUS) ? reg_wdata[STATUS_W-1:0] : '0;

  // ****************************************************************
  // condition input: synchroniser and deglitch
  // ****************************************************************
  // three stages; level accepted only once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync_reg        <= 3'h0;
      limit_level_reg <= 1'b0;
    end
    else
    begin
      sync_reg <= {sync_reg[1:0], limit_hit};
      if (sync_reg[1] == sync_reg[2])
        limit_level_reg <= sync_reg[2];
    end
  end

  clf_deglitch u_deglitch (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .cond_in  (limit_level_reg),
    .deg_code (current_limit_lock_deglitch),
    .cond_out (limit_filt)
  );

  clf_retry_timer #(
    .CYCLES (RETRY_CYCLES)
  ) u_retry_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (state_reg == CLF_WAIT),
    .done     (retry_done)
  );

  // ****************************************************************
  // fault state machine
  // ****************************************************************
  // a detection only counts while the stage is running normally
  assign det_evt  = limit_filt && !det_off && (state_reg == CLF_IDLE); // R6
  assign cnt_over = (retry_count_limit != 5'h00) && (retry_cnt_reg >= retry_count_limit); // R4

  // next state; software clear and restart both release a latched fault
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CLF_IDLE:
      begin
        if (det_evt && det_auto && !cnt_over)
          state_next = CLF_WAIT; // R3
        else if (det_evt)
          state_next = CLF_LATCHED; // R2 R4
      end
      CLF_WAIT:
      begin
        if (fault_restart)
          state_next = CLF_IDLE;
        else if (retry_done)
          state_next = CLF_IDLE; // R3
      end
      CLF_LATCHED:
      begin
        if (fault_clear || fault_restart)
          state_next = CLF_IDLE;
      end
      default: state_next = CLF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_reg <= CLF_IDLE;
    else
      state_reg <= state_next;
  end

  // retry counter; saturates so a long no-limit run cannot wrap
  always_comb
  begin
    retry_cnt_next = retry_cnt_reg;
    if (fault_clear || fault_restart)
      retry_cnt_next = 5'h00; // R9
    else if (det_evt && det_auto && retry_cnt_reg != 5'h1F)
      retry_cnt_next = retry_cnt_reg + 5'h01; // R4
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      retry_cnt_reg <= 5'h00;
    else
      retry_cnt_reg <= retry_cnt_next;
  end

  // ****************************************************************
  // power stage and fault pin
  // ****************************************************************
  // in any fault state the selected reaction overrides the commands
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      hs_gate      <= 3'h0;
      ls_gate      <= 3'h0;
      stage_hiz    <= 1'b1;
      stage_recirc <= 1'b0;
    end
    else if (state_reg == CLF_IDLE)
    begin
      hs_gate      <= hs_cmd;
      ls_gate      <= ls_cmd;
      stage_hiz    <= 1'b0;
      stage_recirc <= 1'b0;
    end
    else
    begin
      hs_gate      <= (det_action == CLF_ACT_HS_BRAKE) ? 3'h7 : 3'h0; // R5
      ls_gate      <= (det_action == CLF_ACT_LS_BRAKE) ? 3'h7 : 3'h0; // R5
      stage_hiz    <= (det_action == CLF_ACT_TRISTATE); // R2
      stage_recirc <= (det_action == CLF_ACT_RECIRC); // R2
    end
  end

  // fault pin low while any lock fault is active
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      fault_indication_out_n <= 1'b1;
    else
      fault_indication_out_n <= (state_reg == CLF_IDLE); // R2
  end

  // threshold code goes to the no-motor comparator through one register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      no_motor_current_threshold <= 3'h0;
    else
      no_motor_current_threshold <= cfg2_reg[THR_LSB +: 3]; // R1
  end

  // ****************************************************************
  // register file and interrupt
  // ****************************************************************
  // configuration is plain read/write, reserved bit kept as written
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cfg2_reg <= CFG2_RESET;
    else if (wr_cfg2)
      cfg2_reg <= reg_wdata; // R8
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mask_reg <= MASK_RESET;
    else if (reg_wr && reg_addr == OFS_MASK)
      mask_reg <= reg_wdata[STATUS_W-1:0];
  end

  // sticky events; a set in the clearing cycle wins over the clear
  assign status_set[ST_DETECT]  = det_evt;
  assign status_set[ST_LATCH]   = (state_next == CLF_LATCHED) && (state_reg != CLF_LATCHED);
  assign status_set[ST_AUTOCLR] = (state_reg == CLF_WAIT) && retry_done && !fault_restart;
  assign status_next            = (status_reg & ~w1c) | status_set;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !reg_rd)
      reg_rdata <= '0;
    else
    begin
      case (reg_addr)
        OFS_CFG2:   reg_rdata <= cfg2_reg;
        OFS_STATUS: reg_rdata <= DATA_W'(status_reg);
        OFS_MASK:   reg_rdata <= DATA_W'(mask_reg);
        OFS_STATE:  reg_rdata <= DATA_W'({retry_cnt_reg, limit_filt, state_reg});
        default:    reg_rdata <= '0;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_thr_follow: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    wr_cfg2 |=> ##1 no_motor_current_threshold == $past(reg_wdata[THR_LSB +: 3], 2))
    else $error("threshold output does not follow the written code");

  a_latch_react: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    det_evt && !det_auto |=> state_reg == CLF_LATCHED ##1 !fault_indication_out_n)
    else $error("latched reaction did not latch and flag the fault");

  a_auto_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    state_reg == CLF_WAIT && retry_done && !fault_restart |=> state_reg == CLF_IDLE ##1 fault_indication_out_n)
    else $error("automatic fault not cleared after the retry interval");

  a_retry_over: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    det_evt && det_auto && retry_count_limit != 5'h00 && retry_cnt_reg >= retry_count_limit
    |=> state_reg == CLF_LATCHED)
    else $error("retry limit exceeded without latching");

  a_hs_brake: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    state_reg != CLF_IDLE && det_action == CLF_ACT_HS_BRAKE |=> hs_gate == 3'h7 && ls_gate == 3'h0)
    else $error("high-side brake not applied");

  a_ls_brake: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    state_reg != CLF_IDLE && det_action == CLF_ACT_LS_BRAKE |=> ls_gate == 3'h7 && hs_gate == 3'h0)
    else $error("low-side brake not applied");

  a_det_off: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
    state_reg == CLF_IDLE && det_off |=> state_reg == CLF_IDLE)
    else $error("fault raised while detection is disabled");

  a_cnt_reset: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
    fault_clear || fault_restart |=> retry_cnt_reg == 5'h00)
    else $error("retry counter not reset on clear");

  a_tristate: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    state_reg != CLF_IDLE && det_action == CLF_ACT_TRISTATE |=> stage_hiz && hs_gate == 3'h0 && ls_gate == 3'h0)
    else $error("tristate reaction not applied");

  a_recirc_react: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    state_reg != CLF_IDLE && det_action == CLF_ACT_RECIRC |=> stage_recirc && hs_gate == 3'h0 && ls_gate == 3'h0)
    else $error("recirculation reaction not applied");

  a_auto_wait: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    det_evt && det_auto && !cnt_over |=> state_reg == CLF_WAIT)
    else $error("automatic reaction did not enter the retry wait");

  a_fault_pin: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    state_reg != CLF_IDLE |=> !fault_indication_out_n)
    else $error("fault pin not driven low during a lock fault");

endmodule

`default_nettype wire

// file: testbench/clf_motor_model.sv
// Purpose: stalled motor behind the three-phase gate stage
// Assumes: supply current needs one high-side and one low-side switch on
// Notes:   brake, recirculation and tristate draw no supply current
`default_nettype none

module clf_motor_model
(
  // gate stage
  input  wire logic [2:0] hs_gate,
  input  wire logic [2:0] ls_gate,
  input  wire logic       stage_hiz,
  input  wire logic       stage_recirc,
  // rotor condition set by the bench
  input  wire logic       rotor_stuck,
  // current comparator
  output var  logic       limit_hit
);
  timeunit 1ns;
  timeprecision 1ns;

  // a stuck rotor lets current rise to the limit only through a bridge path
  always_comb
  begin
    limit_hit = rotor_stuck && (|hs_gate) && (|ls_gate) && !stage_hiz && !stage_recirc;
  end
endmodule

`default_nettype wire

// file: testbench/clf_lock_fault_ctrl_bench.sv
// Purpose: self-checking bench for the current-limit lock fault block
// Assumes: retry interval shortened to 20 cycles, stuck rotor drives the comparator
// Notes:   reference status and mask kept here, used for the status read and interrupt checks
`default_nettype none

module clf_lock_fault_ctrl_bench
  import clf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // signals and reference state
  // ****************************************************************
  localparam int RETRY_SIM = 20;
  logic              core_clk        = 1'b0;
  logic              sys_rst         = 1'b1;
  logic [ADDR_W-1:0] reg_addr        = '0;
  logic [DATA_W-1:0] reg_wdata       = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_wr          = 1'b0;
  logic              reg_rd          = 1'b0;
  logic              limit_hit;
  logic              rotor_stuck     = 1'b0;
  logic [2:0]        threshold;
  logic [2:0]        hs_cmd          = 3'h1;
  logic [2:0]        ls_cmd          = 3'h2;
  logic [2:0]        hs_gate;
  logic [2:0]        ls_gate;
  logic              stage_hiz;
  logic              stage_recirc;
  logic              fault_n;
  logic              irq;
  logic [31:0]       lfsr_state      = 32'hA59A_22AF;
  logic [2:0]        ref_status      = 3'h0;
  logic [2:0]        ref_mask        = MASK_RESET;
  int                miscompares     = 0;
  int                samples_checked = 0;

  // 50 ns period
  always #25 core_clk = ~core_clk;

  clf_lock_fault_ctrl #(.RETRY_CYCLES(RETRY_SIM)) dut (
    .core_clk                   (core_clk),
    .sys_rst                    (sys_rst),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .limit_hit                  (limit_hit),
    .no_motor_current_threshold (threshold),
    .hs_cmd                     (hs_cmd),
    .ls_cmd                     (ls_cmd),
    .hs_gate                    (hs_gate),
    .ls_gate                    (ls_gate),
    .stage_hiz                  (stage_hiz),
    .stage_recirc               (stage_recirc),
    .fault_indication_out_n     (fault_n),
    .irq                        (irq)
  );

  clf_motor_model motor (
    .hs_gate      (hs_gate),
    .ls_gate      (ls_gate),
    .stage_hiz    (stage_hiz),
    .stage_recirc (stage_recirc),
    .rotor_stuck  (rotor_stuck),
    .limit_hit    (limit_hit)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr_next();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state;
  endfunction

  // expected {hs, ls, hiz, recirc} for each reaction action
  function automatic logic [7:0] stage_exp(input logic [1:0] act);
    case (act)
      2'h0:    stage_exp = {3'h0, 3'h0, 2'b10};
      2'h1:    stage_exp = {3'h0, 3'h0, 2'b01};
      2'h2:    stage_exp = {3'h7, 3'h0, 2'b00};
      default: stage_exp = {3'h0, 3'h7, 2'b00};
    endcase
  endfunction

  // allowed retry attempts for retry limit codes 1 to 4
  function automatic int retries_for(input int code);
    case (code)
      1:       retries_for = 2;
      2:       retries_for = 3;
      3:       retries_for = 5;
      default: retries_for = 7;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one-cycle write strobe; reference registers follow the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    if (a == OFS_MASK)
      ref_mask = d[2:0];
    if (a == OFS_STATUS)
      ref_status &= ~d[2:0];
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  // bounded wait for the fault pin, returns cycles taken
  task automatic wait_fault(input logic lvl, input int bound, output int n);
    n = 0;
    while (fault_n !== lvl)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > bound)
      begin
        miscompares++;
        $display("Error at %0t: wait ran out, seen %h expected %h", $time, fault_n, lvl);
        give_verdict();
      end
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    logic [31:0] v;
    int          n;
    int          deg;
    int          rc;
    int          lim;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    // reset values; control and an unmapped hole read zero
    rd_chk(OFS_CFG2, CFG2_RESET);
    rd_chk(OFS_MASK, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_CTRL, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    // random words, every threshold code, reserved bit both ways
    for (int i = 0; i < 8; i++)
    begin
      v = lfsr_next();
      v[21:19] = i[2:0];
      v[11] = i[0];
      wr(OFS_CFG2, v);
      wr(8'h40, ~v);
      {hs_cmd, ls_cmd} <= v[5:0];
      rd_chk(OFS_CFG2, v);
      check(threshold, i[2:0]);
      check({hs_gate, ls_gate}, v[5:0]);
    end
    @(posedge core_clk);
    hs_cmd <= 3'h1;
    ls_cmd <= 3'h2;
    // reaction i with deglitch i; auto codes use retry codes 1-4, latch after the last retry
    for (int i = 0; i < 8; i++)
    begin
      deg = i * CYCLES_PER_US;
      wr(OFS_MASK, i[0] ? 32'h0000_0000 : 32'h0000_0007);
      rc  = (i < 4) ? 1 : i - 3;
      lim = retries_for(rc);
      wr(OFS_CFG2, (i << DEG_LSB) | (i << REACT_LSB) | rc);
      if (i > 0)
      begin
        // one sample short of the deglitch time
        rotor_stuck <= 1'b1;
        repeat (deg - 1) @(posedge core_clk);
        rotor_stuck <= 1'b0;
        repeat (30) @(posedge core_clk);
        #1;
        check(fault_n, 1'b1);
      end
      @(posedge core_clk);
      rotor_stuck <= 1'b1;
      for (int k = 0; k <= lim; k++)
      begin
        wait_fault(1'b0, deg + 40, n);
        if (k == 0)
          check(n >= deg && n <= deg + 15, 1'b1);
        check({hs_gate, ls_gate, stage_hiz, stage_recirc}, stage_exp(i[1:0]));
        if (i < 4 || k == lim)
          break;
        wait_fault(1'b1, RETRY_SIM + 10, n);
        check(n >= RETRY_SIM, 1'b1);
      end
      repeat (RETRY_SIM + 10) @(posedge core_clk);
      #1;
      check(fault_n, 1'b0);
      ref_status = (i < 4) ? 3'h3 : 3'h7;
      rd_chk(OFS_STATUS, ref_status);
      check(irq, |(ref_status & ref_mask));
      rd(OFS_STATE, v);
      check(v[1:0], 2'h2);
      check(v[7:3], (i < 4) ? 0 : lim + 1);
      @(posedge core_clk);
      rotor_stuck <= 1'b0;
      wr(OFS_STATUS, 32'h0000_0007);
      wr(OFS_CTRL, i[1] ? 32'h0000_0002 : 32'h0000_0001);
      rd(OFS_STATE, v);
      check(v, 32'h0000_0000);
      check({fault_n, irq}, 2'b10);
    end
    // disabled reaction codes never fault
    for (int r = 8; r < 16; r++)
    begin
      wr(OFS_CFG2, r << REACT_LSB);
      rotor_stuck <= 1'b1;
      repeat (40) @(posedge core_clk);
      rotor_stuck <= 1'b0;
      #1;
      check({fault_n, hs_gate, ls_gate}, {1'b1, hs_cmd, ls_cmd});
    end
    rd_chk(OFS_STATUS, 32'h0000_0000);
    give_verdict();
  end
endmodule

`default_nettype wire
